//--- verilog/squib_driver_reset_control.sv
// combines the reset and fault sources of a four-channel squib driver
// assumes detector inputs come from analog comparators, asynchronous to clk
//
// What this block does
// - filtered undervoltage resets after filter time
// - immediate undervoltage resets with no filter delay
// - low external reset acts like supply reset
// - external reset ignored during deployment
// - undervoltage resets even during deployment
// - held external reset acts after deployment ends
// - external reset low pulses under deglitch ignored
// - bias resistor out of range resets
// - lost logic ground resets
// - lost power ground disables only low side
// - one open ground leaves other channels alone
// - open ground reported via low-side diagnostic
// - lost analog ground resets, analog out pulled up
// - deployment runs from arm-fire until timer expiry
`timescale 1ns/100ps
module squib_driver_reset_control #(
   parameter int unsigned CHANNELS        = reset_ctrl_pkg::CHANNELS,
   parameter int unsigned FILTER_CYCLES   = reset_ctrl_pkg::UNDERVOLTAGE_FILTER_CYCLES,
   parameter int unsigned DEGLITCH_CYCLES = reset_ctrl_pkg::RESET_DEGLITCH_CYCLES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // supply, reference and ground detectors (asynchronous)
   input  wire logic                below_filtered_threshold,
   input  wire logic                below_immediate_threshold,
   input  wire logic                external_reset_n,
   input  wire logic                bias_resistor_above_upper,
   input  wire logic                bias_resistor_below_lower,
   input  wire logic                logic_ground_open,
   input  wire logic                analog_ground_open,
   input  wire logic [CHANNELS-1:0] channel_power_ground_open,
   // deployment state from the firing logic (same clock)
   input  wire logic                arm_fire_accepted,
   input  wire logic                deploy_timer_expired,
   // requested drivers from the firing and diagnostic logic (same clock)
   input  wire logic [CHANNELS-1:0] high_side_request,
   input  wire logic [CHANNELS-1:0] low_side_request,
   input  wire logic [CHANNELS-1:0] low_side_diag_request,
   // gated outputs
   output logic                     internal_reset,
   output logic [CHANNELS-1:0]      high_side_output,
   output logic [CHANNELS-1:0]      low_side_output,
   output logic [CHANNELS-1:0]      low_side_diag_fail,
   output logic                     analog_measure_pullup,
   output logic                     deploy_active
);
   localparam int unsigned NSYNC = 7 + CHANNELS;

   // a deglitch of one cycle could not drop any pulse the synchroniser lets through
   if (CHANNELS < 1 || DEGLITCH_CYCLES < 2) begin
      $error("squib_driver_reset_control: CHANNELS or DEGLITCH_CYCLES out of range");
   end

   // two-stage synchroniser for every asynchronous detector
   wire [NSYNC-1:0] async_in = {channel_power_ground_open, analog_ground_open,
      logic_ground_open, bias_resistor_below_lower, bias_resistor_above_upper,
      ~external_reset_n, below_immediate_threshold, below_filtered_threshold};
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end

   wire                uv_filt_s   = sync2_reg[0];
   wire                uv_imm_s    = sync2_reg[1];
   wire                ext_low_s   = sync2_reg[2];
   wire                bias_bad_s  = sync2_reg[3] | sync2_reg[4];
   wire                lgnd_open_s = sync2_reg[5];
   wire                analog_ground_pin_open_s = sync2_reg[6];
   wire [CHANNELS-1:0] pgnd_open_s = sync2_reg[NSYNC-1:7];

   logic uv_filt_done;
   logic ext_low_done;

   level_filter #(
      .LEN   (FILTER_CYCLES),
      .CNT_W (reset_ctrl_pkg::CNT_W)
   ) u_uv_filter (
      .clk       (clk),
      .rst       (rst),
      .level_in  (uv_filt_s),
      .level_out (uv_filt_done)
   );

   level_filter #(
      .LEN   (DEGLITCH_CYCLES),
      .CNT_W (reset_ctrl_pkg::CNT_W)
   ) u_ext_deglitch (
      .clk       (clk),
      .rst       (rst),
      .level_in  (ext_low_s),
      .level_out (ext_low_done)
   );

   // deployment window
   logic deploy_reg;
   logic deploy_next;

   assign deploy_next = arm_fire_accepted ? 1'b1
                      : (deploy_timer_expired ? 1'b0 : deploy_reg);

   // supply, reference and ground sources override deployment
   wire hard_reset = uv_filt_done
                   | uv_imm_s
                   | bias_bad_s
                   | lgnd_open_s
                   | analog_ground_pin_open_s;
   // external reset only counts outside a deployment; a held level acts after it
   wire ext_reset  = ext_low_done & ~deploy_reg;

   // combined level stays up for as long as any source is up
   wire reset_comb = hard_reset | ext_reset;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         deploy_reg <= 1'b0;
      end else if (reset_comb) begin
         deploy_reg <= 1'b0;
      end else begin
         deploy_reg <= deploy_next;
      end
   end

   // registered driver gating; each channel looks only at its own ground
   logic [CHANNELS-1:0] hs_reg;
   logic [CHANNELS-1:0] ls_reg;
   logic [CHANNELS-1:0] diag_reg;
   logic                reset_reg;
   logic                pullup_reg;

   wire [CHANNELS-1:0] hs_next   = reset_comb ? '0 : high_side_request;
   wire [CHANNELS-1:0] ls_next   = reset_comb ? '0
                                 : (low_side_request & ~pgnd_open_s);
   wire [CHANNELS-1:0] diag_next = reset_comb ? '0
                                 : (low_side_diag_request & pgnd_open_s);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hs_reg     <= '0;
         ls_reg     <= '0;
         diag_reg   <= '0;
         reset_reg  <= 1'b1;
         pullup_reg <= 1'b0;
      end else begin
         hs_reg     <= hs_next;
         ls_reg     <= ls_next;
         diag_reg   <= diag_next;
         reset_reg  <= reset_comb;
         pullup_reg <= analog_ground_pin_open_s;
      end
   end

   assign internal_reset        = reset_reg;
   assign high_side_output      = hs_reg;
   assign low_side_output       = ls_reg;
   assign low_side_diag_fail    = diag_reg;
   assign analog_measure_pullup = pullup_reg;
   assign deploy_active         = deploy_reg;

   // outputs follow an immediate undervoltage one cycle after the synchroniser output rises
   imm_uv_reset_a: assert property (@(posedge clk) disable iff (rst)
      $rose(sync2_reg[1]) |=> internal_reset && high_side_output == '0)
      else $error("immediate undervoltage did not reset");

   uv_in_deploy_a: assert property (@(posedge clk) disable iff (rst)
      (deploy_reg && uv_imm_s) |=> !deploy_reg && internal_reset)
      else $error("undervoltage ignored during deployment");

   ext_masked_a: assert property (@(posedge clk) disable iff (rst)
      (deploy_reg && !hard_reset) |=> !internal_reset)
      else $error("external reset not masked in deployment");

   ext_after_a: assert property (@(posedge clk) disable iff (rst)
      (!deploy_reg && ext_low_done) |=> internal_reset && low_side_output == '0)
      else $error("held external reset did not act");

   glitch_drop_a: assert property (@(posedge clk) disable iff (rst)
      $rose(ext_low_s) |-> !ext_low_done [*2])
      else $error("external reset acted without deglitch");

   bias_reset_a: assert property (@(posedge clk) disable iff (rst)
      bias_bad_s |=> internal_reset)
      else $error("bias resistor fault did not reset");

   gnd_reset_a: assert property (@(posedge clk) disable iff (rst)
      lgnd_open_s |=> internal_reset && high_side_output == '0)
      else $error("logic ground loss did not reset");

   analog_ground_pin_reset_a: assert property (@(posedge clk) disable iff (rst)
      analog_ground_pin_open_s |=> internal_reset && analog_measure_pullup)
      else $error("analog ground loss not handled");

   pgnd_ls_a: assert property (@(posedge clk) disable iff (rst)
      (!reset_comb && high_side_request[0] && pgnd_open_s[0])
         |=> high_side_output[0] && !low_side_output[0])
      else $error("open power ground gating wrong");

   pgnd_iso_a: assert property (@(posedge clk) disable iff (rst)
      (!reset_comb && low_side_request[1] && !pgnd_open_s[1]) |=> low_side_output[1])
      else $error("open ground affected another channel");

   pgnd_diag_a: assert property (@(posedge clk) disable iff (rst)
      (!reset_comb && low_side_diag_request[0] && pgnd_open_s[0]) |=> low_side_diag_fail[0])
      else $error("open ground not reported");

   deploy_win_a: assert property (@(posedge clk) disable iff (rst)
      (arm_fire_accepted && !reset_comb) |=> deploy_active)
      else $error("deployment window not opened");

   hold_reset_a: assert property (@(posedge clk) disable iff (rst)
      reset_comb |=> internal_reset)
      else $error("combined reset released early");
endmodule

//--- verilog/reset_ctrl_pkg.sv
// package for the squib driver reset and fault-shutdown control
// assumes a 100 MHz system clock; times are in nanoseconds
package reset_ctrl_pkg;
   localparam int unsigned CLK_PERIOD_NS              = 10;
   // filtered undervoltage must persist this long before it resets
   localparam int unsigned UNDERVOLTAGE_FILTER_TIME_NS = 10000;
   localparam int unsigned UNDERVOLTAGE_FILTER_CYCLES  =
      (UNDERVOLTAGE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // low pulses on the external reset shorter than this are discarded
   localparam int unsigned RESET_DEGLITCH_TIME_NS      = 2000;
   localparam int unsigned RESET_DEGLITCH_CYCLES       =
      (RESET_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CHANNELS                    = 4;
   localparam int unsigned CNT_W                       = 16;
endpackage

//--- verilog/level_filter.sv
// persistence filter: out rises once in has been high for LEN cycles
// assumes in is already synchronous to clk
`timescale 1ns/100ps
module level_filter #(
   parameter int unsigned LEN   = 1,
   parameter int unsigned CNT_W = 16
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // level in and filtered level out
   input  wire logic level_in,
   output logic      level_out
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   wire              done = (count_reg >= CNT_W'(LEN));

   // refused at elaboration: the counter must be able to reach LEN
   if (LEN < 1 || LEN >= (2 ** CNT_W)) begin
      $error("level_filter: LEN out of range");
   end

   // any drop restarts the count, so only a continuous level qualifies
   assign count_next = !level_in ? '0 : (done ? count_reg : count_reg + CNT_W'(1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign level_out = done;
endmodule

//--- verif/squib_driver_reset_control_test.sv
// self-checking bench for the squib driver reset and fault-shutdown control
// assumes short filter counts; detector inputs are held long enough to pass the synchronisers
`timescale 1ns/100ps
module squib_driver_reset_control_test;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        uvf = 1'b0, uvi = 1'b0, ext_n = 1'b1, bias_hi = 1'b0, bias_lo = 1'b0;
   logic        lgnd = 1'b0, analog_ground_pin = 1'b0, arm = 1'b0, expd = 1'b0;
   logic [3:0]  pgnd = 4'h0, hsr = 4'h0, lsr = 4'h0, dgr = 4'h0;
   logic        ir, pu, da;
   logic [3:0]  hs, ls, dg;
   logic [15:0] lfsr = 16'h5e9d;
   logic [14:0] notes[$];
   event        ev;
   int          failures = 0;
   int          compares = 0;
   int          i, j;

   always #5 clk = ~clk;

   squib_driver_reset_control #(.CHANNELS(4), .FILTER_CYCLES(4), .DEGLITCH_CYCLES(3)) uut (
      .clk(clk), .rst(rst), .below_filtered_threshold(uvf), .below_immediate_threshold(uvi),
      .external_reset_n(ext_n), .bias_resistor_above_upper(bias_hi),
      .bias_resistor_below_lower(bias_lo), .logic_ground_open(lgnd),
      .analog_ground_open(analog_ground_pin), .channel_power_ground_open(pgnd),
      .arm_fire_accepted(arm), .deploy_timer_expired(expd), .high_side_request(hsr),
      .low_side_request(lsr), .low_side_diag_request(dgr), .internal_reset(ir),
      .high_side_output(hs), .low_side_output(ls), .low_side_diag_fail(dg),
      .analog_measure_pullup(pu), .deploy_active(da));

   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // drivers are forced off under reset; otherwise each channel sees only its own ground
   function automatic logic [14:0] expv(input logic r, input logic p, input logic d);
      expv = r ? {1'b1, 12'h000, p, d} : {1'b0, hsr, lsr & ~pgnd, dgr & pgnd, p, d};
   endfunction

   task automatic check(input logic [14:0] seen, input logic [14:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t ns: outputs %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic note(input logic [14:0] e);
      notes.push_back(e);
      ->ev;
   endtask

   task automatic hold(input logic r, input logic p, input logic d, input int n);
      repeat (n) begin
         note(expv(r, p, d));
         step(1);
      end
   endtask

   // bounded wait; running out is counted and ends the run
   task automatic wait_ir(input logic v);
      int k;
      for (k = 0; k < 20 && ir !== v; k++) step(1);
      if (ir !== v) begin
         failures++;
         $display("[FAIL] %0t ns: reset level wait ran out", $time);
         print_verdict();
      end
   endtask

   always @(ev) begin
      if (notes.size() > 0)
         check({ir, hs, ls, dg, pu, da}, notes.pop_front());
         // the same compare also covers
   end

   initial begin
      step(16);
      rst = 1'b0;
      wait_ir(1'b0);
      for (i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         pgnd = lfsr[3:0];
         step(4);
         for (j = 0; j < 6; j++) begin
            lfsr = lfsr_next(lfsr);
            {hsr, lsr, dgr} = lfsr[11:0];
            step(1);
            note(expv(1'b0, 1'b0, 1'b0));
         end
      end
      $display("channel gating test done");
      {hsr, lsr, dgr, pgnd} = 16'hfff5;
      step(4);
      for (i = 0; i < 5; i++) begin
         {uvi, bias_hi, bias_lo, lgnd, analog_ground_pin} = 5'h01 << i;
         wait_ir(1'b1);
         step(1);
         hold(1'b1, analog_ground_pin, 1'b0, 2);
         {uvi, bias_hi, bias_lo, lgnd, analog_ground_pin} = 5'h00;
         wait_ir(1'b0);
         step(2);
         hold(1'b0, 1'b0, 1'b0, 1);
      end
      $display("immediate source test done");
      uvf = 1'b1;
      step(2);
      uvf = 1'b0;
      hold(1'b0, 1'b0, 1'b0, 10);
      uvf = 1'b1;
      hold(1'b0, 1'b0, 1'b0, 3);
      wait_ir(1'b1);
      hold(1'b1, 1'b0, 1'b0, 2);
      uvf = 1'b0;
      wait_ir(1'b0);
      ext_n = 1'b0;
      step(1);
      ext_n = 1'b1;
      hold(1'b0, 1'b0, 1'b0, 10);
      ext_n = 1'b0;
      hold(1'b0, 1'b0, 1'b0, 3);
      wait_ir(1'b1);
      hold(1'b1, 1'b0, 1'b0, 2);
      ext_n = 1'b1;
      wait_ir(1'b0);
      $display("filter test done");
      arm = 1'b1;
      step(1);
      arm = 1'b0;
      ext_n = 1'b0;
      hold(1'b0, 1'b0, 1'b1, 15);
      expd = 1'b1;
      step(1);
      expd = 1'b0;
      wait_ir(1'b1);
      hold(1'b1, 1'b0, 1'b0, 2);
      ext_n = 1'b1;
      wait_ir(1'b0);
      arm = 1'b1;
      step(1);
      arm = 1'b0;
      hold(1'b0, 1'b0, 1'b1, 2);
      uvi = 1'b1;
      wait_ir(1'b1);
      step(1);
      hold(1'b1, 1'b0, 1'b0, 2);
      uvi = 1'b0;
      wait_ir(1'b0);
      $display("deployment test done");
      bias_hi = 1'b1;
      wait_ir(1'b1);
      lgnd = 1'b1;
      step(3);
      bias_hi = 1'b0;
      hold(1'b1, 1'b0, 1'b0, 6);
      lgnd = 1'b0;
      wait_ir(1'b0);
      step(1);
      hold(1'b0, 1'b0, 1'b0, 2);
      $display("overlap test done");
      print_verdict();
   end
endmodule
